// ===== core/sdpm_los_det.sv
// Signal-loss detector on the raw line before descrambling
`timescale 1ns/100ps
module sdpm_los_det #(
  parameter int DETECT_CYC = sdpm_pkg::LOS_DETECT_CYC,
  parameter int CLEAR_CYC = sdpm_pkg::FRAME_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Line
  input wire logic line_bit_in,
  // Defect
  output logic los_out
);

  logic prev_q, prev_d;
  logic [15:0] quiet_q, quiet_d;
  logic [15:0] ok_q, ok_d;
  logic los_q, los_d;

  // Quiet and clean run counters
  always_comb begin
    prev_d = line_bit_in;
    los_d = los_q;
    quiet_d = quiet_q + 16'h1;
    if (quiet_q == 16'(DETECT_CYC)) begin
      quiet_d = quiet_q;   // Saturate, but a transition still restarts the run
    end
    if (line_bit_in != prev_q) begin
      quiet_d = 16'h0;
    end
    ok_d = ok_q;
    if (quiet_q >= 16'(DETECT_CYC)) begin
      los_d = 1'b1;
      ok_d = 16'h0;
    end else if (los_q) begin
      ok_d = ok_q + 16'h1;
      if (ok_q + 16'h1 >= 16'(CLEAR_CYC)) begin
        los_d = 1'b0;
        ok_d = 16'h0;
      end
    end
  end

  // Registers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_q <= 1'b0;
      quiet_q <= 16'h0;
      ok_q <= 16'h0;
      los_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      quiet_q <= quiet_d;
      ok_q <= ok_d;
      los_q <= los_d;
    end
  end

  assign los_out = los_q;

endmodule : sdpm_los_det

// ===== core/sdpm_monitor.sv
// Line defect detection and per-interval performance counters
`timescale 1ns/100ps
module sdpm_monitor #(
  parameter int FRAMES_PER_SEC = sdpm_pkg::FRAMES_PER_SEC,
  parameter int SECS_PER_INTERVAL = sdpm_pkg::SECS_PER_INTERVAL,
  parameter int NUM_INTERVALS = sdpm_pkg::NUM_INTERVALS
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Receive line
  input wire logic line_bit_in,
  input wire sdpm_pkg::sdpm_frame_t frame_in,
  // Management commands
  input wire logic clear_current_in,
  input wire logic clear_intervals_in,
  input wire logic clear_confirm_in,
  input wire logic [6:0] interval_sel_in,
  // Defects and second tick
  output logic frame_alignment_loss_out,
  output logic signal_loss_out,
  output logic pointer_loss_out,
  output logic second_tick_out,
  // Counters
  output sdpm_pkg::sdpm_counts_t current_out,
  output sdpm_pkg::sdpm_counts_t history_out,
  output sdpm_pkg::sdpm_counts_t day_out,
  output logic [9:0] elapsed_sec_out
);

  localparam int W = sdpm_pkg::CNT_W;

  // ----------------------------------------------------------------
  // Signal loss
  // ----------------------------------------------------------------
  logic los;
  sdpm_los_det u_los (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .line_bit_in(line_bit_in),
    .los_out(los)
  );

  // ----------------------------------------------------------------
  // Frame alignment and pointer defects
  // ----------------------------------------------------------------
  logic [3:0] faw_bad_q, faw_bad_d, faw_good_q, faw_good_d, ptr_bad_q, ptr_bad_d;
  logic fal_q, fal_d, ptr_q, ptr_d;

  // Consecutive frame counters
  always_comb begin
    faw_bad_d = faw_bad_q;
    faw_good_d = faw_good_q;
    ptr_bad_d = ptr_bad_q;
    fal_d = fal_q;
    ptr_d = ptr_q;
    if (frame_in.frame_start) begin
      if (frame_in.faw_error) begin
        faw_good_d = 4'h0;
        faw_bad_d = (faw_bad_q < sdpm_pkg::FAW_BAD_DECLARE) ? faw_bad_q + 4'h1 : faw_bad_q;
        if (faw_bad_q + 4'h1 >= sdpm_pkg::FAW_BAD_DECLARE) begin
          fal_d = 1'b1;
        end
      end else begin
        faw_bad_d = 4'h0;
        faw_good_d = (faw_good_q < sdpm_pkg::FAW_GOOD_CLEAR) ? faw_good_q + 4'h1 : faw_good_q;
        if (faw_good_q + 4'h1 >= sdpm_pkg::FAW_GOOD_CLEAR) begin
          fal_d = 1'b0;
        end
      end
      if (frame_in.ptr_valid) begin
        ptr_bad_d = 4'h0;
        ptr_d = 1'b0;
      end else begin
        ptr_bad_d = (ptr_bad_q < sdpm_pkg::PTR_BAD_DECLARE) ? ptr_bad_q + 4'h1 : ptr_bad_q;
        if (ptr_bad_q + 4'h1 >= sdpm_pkg::PTR_BAD_DECLARE) begin
          ptr_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      faw_bad_q <= 4'h0;
      faw_good_q <= 4'h0;
      ptr_bad_q <= 4'h0;
      fal_q <= 1'b0;
      ptr_q <= 1'b0;
    end else begin
      faw_bad_q <= faw_bad_d;
      faw_good_q <= faw_good_d;
      ptr_bad_q <= ptr_bad_d;
      fal_q <= fal_d;
      ptr_q <= ptr_d;
    end
  end

  logic ptr_report;
  assign ptr_report = ptr_q && !frame_in.ais;

  // ----------------------------------------------------------------
  // Second tick and per-second event capture
  // ----------------------------------------------------------------
  logic [13:0] fcnt_q, fcnt_d;
  logic [9:0] sec_q, sec_d;
  logic tick, ivl_end;
  logic [7:0] ev_q, ev_d;   // Error events seen this second
  logic fal_sec_q, fal_sec_d;
  logic any_ev;

  assign tick = frame_in.frame_start && (fcnt_q == 14'(FRAMES_PER_SEC - 1));
  assign ivl_end = tick && (sec_q == 10'(SECS_PER_INTERVAL - 1));
  assign any_ev = fal_q || los || ptr_report || frame_in.ais;

  // Frame and second counting, event accumulation
  always_comb begin
    fcnt_d = fcnt_q;
    sec_d = sec_q;
    ev_d = ev_q;
    fal_sec_d = fal_sec_q || fal_q;
    if (any_ev && frame_in.frame_start && ev_q != 8'hff) begin
      ev_d = ev_q + 8'h1;
    end
    if (frame_in.frame_start) begin
      fcnt_d = tick ? 14'h0 : fcnt_q + 14'h1;
    end
    if (tick) begin
      sec_d = ivl_end ? 10'h0 : sec_q + 10'h1;
      ev_d = 8'h0;
      fal_sec_d = fal_q;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fcnt_q <= 14'h0;
      sec_q <= 10'h0;
      ev_q <= 8'h0;
      fal_sec_q <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      sec_q <= sec_d;
      ev_q <= ev_d;
      fal_sec_q <= fal_sec_d;
    end
  end

  // ----------------------------------------------------------------
  // Current interval, day and history counters
  // ----------------------------------------------------------------
  sdpm_pkg::sdpm_counts_t cur_q, cur_d, day_q, day_d, hist_q, cur_acc;
  sdpm_pkg::sdpm_counts_t hist_mem [1:NUM_INTERVALS-1];
  logic [NUM_INTERVALS-1:1] hist_ok_q, hist_ok_d;
  logic [6:0] wr_ptr_q, wr_ptr_d;
  logic errsec_now, severe_now, clr_hist;

  // Saturating add used for every current and day counter
  function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v, input logic en);
    sat_inc = (en && v != {W{1'b1}}) ? v + W'(1) : v;
  endfunction : sat_inc

  assign errsec_now = (ev_q != 8'h0) || any_ev;
  // Compare without adding, so a saturated event count cannot wrap
  assign severe_now = (ev_q > 8'h1) || ((ev_q == 8'h1) && any_ev && frame_in.frame_start);
  assign clr_hist = clear_intervals_in && clear_confirm_in;

  // Per-second and per-error accumulation
  always_comb begin
    cur_d = cur_q;
    day_d = day_q;
    hist_ok_d = hist_ok_q;
    wr_ptr_d = wr_ptr_q;
    cur_d.coding_violation_count = sat_inc(cur_q.coding_violation_count, frame_in.b1_error);
    day_d.coding_violation_count = sat_inc(day_q.coding_violation_count, frame_in.b1_error);
    if (tick) begin
      cur_d.errored_second_count = sat_inc(cur_q.errored_second_count, errsec_now);
      cur_d.severe_error_second_count = sat_inc(cur_q.severe_error_second_count, severe_now);
      cur_d.unavailable_second_count = sat_inc(cur_q.unavailable_second_count, fal_sec_q || fal_q);
      day_d.errored_second_count = sat_inc(day_q.errored_second_count, errsec_now);
      day_d.severe_error_second_count = sat_inc(day_q.severe_error_second_count, severe_now);
      day_d.unavailable_second_count = sat_inc(day_q.unavailable_second_count, fal_sec_q || fal_q);
    end
    // Closing totals include the last second and its parity errors
    cur_acc = cur_d;
    if (clr_hist) begin
      hist_ok_d = '0;
      day_d = '0;
    end
    if (ivl_end) begin
      cur_d = '0;
      wr_ptr_d = (wr_ptr_q == 7'(NUM_INTERVALS - 1)) ? 7'h1 : wr_ptr_q + 7'h1;
      hist_ok_d[wr_ptr_q] = 1'b1;   // A closing interval wins over a clear
    end
    if (clear_current_in) begin
      cur_d = '0;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_q <= '0;
      day_q <= '0;
      hist_ok_q <= '0;
      wr_ptr_q <= 7'h1;
    end else begin
      cur_q <= cur_d;
      day_q <= day_d;
      hist_ok_q <= hist_ok_d;
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // History store, written in rotation at wr_ptr_q; selection 1 reads the most recent closed interval
  always_ff @(posedge clock_in) begin
    if (ivl_end) begin
      hist_mem[wr_ptr_q] <= cur_acc;
    end
  end

  // History read, invalid or cleared slots read zero
  logic [6:0] rd_slot;
  always_comb begin
    rd_slot = (wr_ptr_q > interval_sel_in) ? wr_ptr_q - interval_sel_in
                                           : 7'(NUM_INTERVALS - 1) - interval_sel_in + wr_ptr_q;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hist_q <= '0;
    end else if (interval_sel_in == 7'h0) begin
      hist_q <= cur_q;
    end else if (interval_sel_in < 7'(NUM_INTERVALS) && hist_ok_q[rd_slot]) begin
      hist_q <= hist_mem[rd_slot];
    end else begin
      hist_q <= '0;
    end
  end

  // Outputs
  assign frame_alignment_loss_out = fal_q;
  assign signal_loss_out = los;
  assign pointer_loss_out = ptr_report;
  assign second_tick_out = tick;
  assign current_out = cur_q;
  assign history_out = hist_q;
  assign day_out = day_q;
  assign elapsed_sec_out = sec_q;

endmodule : sdpm_monitor

// ===== core/sdpm_pkg.sv
// Package of constants and carrier types for the line defect and performance monitor
package sdpm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  localparam int LOS_DETECT_NS = 2300;   // Quiet window, least time
  localparam int FRAME_NS = 125000;      // One frame period
  localparam int LOS_DETECT_CYC = (LOS_DETECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_CYC = (FRAME_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAMES_PER_SEC = 8000;
  localparam int SECS_PER_INTERVAL = 900;
  localparam int NUM_INTERVALS = 97;     // Slots 0 (current) to 96

  // ----------------------------------------------------------------
  // Defect thresholds and counter width
  // ----------------------------------------------------------------
  localparam logic [3:0] FAW_BAD_DECLARE = 4'h4;
  localparam logic [3:0] FAW_GOOD_CLEAR = 4'h2;
  localparam logic [3:0] PTR_BAD_DECLARE = 4'h8;
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_start;   // One pulse per received frame
    logic faw_error;     // Alignment word of this frame in error
    logic ptr_valid;     // Valid pointer in this frame
    logic ais;           // Alarm indication in overhead
    logic b1_error;      // Parity mismatch from the B1 byte
  } sdpm_frame_t;

  typedef struct packed {
    logic [CNT_W-1:0] errored_second_count;
    logic [CNT_W-1:0] severe_error_second_count;
    logic [CNT_W-1:0] unavailable_second_count;
    logic [CNT_W-1:0] coding_violation_count;
  } sdpm_counts_t;

endpackage : sdpm_pkg

// ===== test/sdpm_line_src.sv
// Remote line equipment model: raw line and frame stream
`timescale 1ns/100ps
module sdpm_line_src #(
  parameter int GAP = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Controls
  input wire logic quiet_in,
  input wire logic faw_bad_in,
  input wire logic ptr_ok_in,
  input wire logic ais_in,
  input wire logic b1_in,
  // Line
  output logic line_bit_out,
  output sdpm_pkg::sdpm_frame_t frame_out
);
  logic [3:0] cnt_q;
  logic bit_q;
  logic fs;
  // Line toggles each cycle unless held quiet
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_q <= 1'b0;
    end else if (!quiet_in) begin
      bit_q <= ~bit_q;
    end
  end
  // One frame start every GAP cycles
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= fs ? 4'h0 : cnt_q + 4'h1;
    end
  end
  assign fs = cnt_q == 4'(GAP - 1);
  assign line_bit_out = bit_q;
  // Alignment and pointer fields carry junk outside a frame start, B1 error is held low
  assign frame_out = {fs, fs ? faw_bad_in : ~faw_bad_in, fs ? ptr_ok_in : ~ptr_ok_in, ais_in, fs & b1_in};
endmodule : sdpm_line_src

// ===== test/sdpm_monitor_checker.sv
// Concurrent checks on the monitor ports
`timescale 1ns/100ps
module sdpm_monitor_checker (
  // Watched ports
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic line_bit_in,
  input wire sdpm_pkg::sdpm_frame_t frame_in,
  input wire logic clear_current_in,
  input wire logic clear_intervals_in,
  input wire logic clear_confirm_in,
  input wire logic frame_alignment_loss_out,
  input wire logic signal_loss_out,
  input wire logic pointer_loss_out,
  input wire logic second_tick_out,
  input wire sdpm_pkg::sdpm_counts_t current_out,
  input wire sdpm_pkg::sdpm_counts_t day_out
);
  logic [3:0] nb_q, ng_q, np_q;
  logic [11:0] quiet_q, clean_q;
  logic lb_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // Run lengths of bad words, good words, missing pointers, quiet line
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {nb_q, ng_q, np_q, quiet_q, clean_q, lb_q} <= '0;
    end else begin
      lb_q <= line_bit_in;
      quiet_q <= (line_bit_in == lb_q) ? quiet_q + {11'h0, ~&quiet_q} : 12'h0;
      clean_q <= (quiet_q >= 12'h03a) ? 12'h0 : clean_q + {11'h0, ~&clean_q};
      if (frame_in.frame_start) begin
        nb_q <= frame_in.faw_error ? nb_q + {3'h0, nb_q != 4'hf} : 4'h0;
        ng_q <= frame_in.faw_error ? 4'h0 : ng_q + {3'h0, ng_q != 4'hf};
        np_q <= frame_in.ptr_valid ? 4'h0 : np_q + {3'h0, np_q != 4'hf};
      end
    end
  end
  sequence bad4_s; frame_in.frame_start && frame_in.faw_error && nb_q == 4'h3; endsequence
  sequence good2_s; frame_in.frame_start && !frame_in.faw_error && ng_q == 4'h1; endsequence
  sequence noptr8_s; frame_in.frame_start && !frame_in.ptr_valid && np_q == 4'h7; endsequence
  faw_set_a:
    assert property (bad4_s |=> frame_alignment_loss_out) else $error("frame loss not set");
  faw_rise_a:
    assert property ($rose(frame_alignment_loss_out) |-> nb_q == 4'h4) else $error("frame loss early");
  faw_clear_a:
    assert property (good2_s |=> !frame_alignment_loss_out) else $error("frame loss not cleared");
  los_max_a:
    assert property (quiet_q == 12'h9c4 |-> signal_loss_out) else $error("signal loss late");
  los_min_a:
    assert property ($rose(signal_loss_out) |-> quiet_q >= 12'h03a) else $error("signal loss early");
  los_clear_a:
    assert property ($fell(signal_loss_out) |-> clean_q >= 12'hc35) else $error("signal loss cleared early");
  ptr_set_a:
    assert property (noptr8_s |=> pointer_loss_out || frame_in.ais) else $error("pointer loss not set");
  ptr_hide_a:
    assert property (frame_in.ais |-> !pointer_loss_out) else $error("pointer loss shown under alarm");
  ptr_clear_a:
    assert property (frame_in.frame_start && frame_in.ptr_valid |=> !pointer_loss_out) else $error("ptr stuck");
  cv_inc_a:
    assert property (frame_in.b1_error && !clear_current_in && !second_tick_out |=>
      current_out.coding_violation_count == $past(current_out.coding_violation_count) + 32'h1)
      else $error("violation not counted");
  cur_clear_a:
    assert property (clear_current_in |=> current_out == '0) else $error("current not cleared");
  day_clear_a:
    assert property (clear_intervals_in && clear_confirm_in |=> day_out == '0) else $error("day not cleared");
  tick_frame_a:
    assert property (second_tick_out |-> frame_in.frame_start) else $error("tick off frame");
endmodule : sdpm_monitor_checker
bind sdpm_monitor sdpm_monitor_checker u_chk (.clock_in, .sys_rst_in, .line_bit_in, .frame_in,
  .clear_current_in, .clear_intervals_in, .clear_confirm_in, .frame_alignment_loss_out,
  .signal_loss_out, .pointer_loss_out, .second_tick_out, .current_out, .day_out);

// ===== test/testbench.sv
// Self-checking bench for the line defect and performance monitor
`timescale 1ns/100ps
module testbench;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic line_bit;
  sdpm_pkg::sdpm_frame_t frame;
  logic clr_cur = 1'b0, clr_int = 1'b0, clr_cfm = 1'b0;
  logic [6:0] sel = 7'h0;
  logic quiet = 1'b0, faw_bad = 1'b0, ptr_ok = 1'b1, ais = 1'b0, b1 = 1'b0;
  logic fal, sl, pl, tick;
  logic [9:0] elapsed;
  sdpm_pkg::sdpm_counts_t cur, hist, day;
  int err_total = 0;
  int cmp_count = 0;
  sdpm_line_src src (.clock_in, .sys_rst_in, .quiet_in(quiet), .faw_bad_in(faw_bad), .ptr_ok_in(ptr_ok),
    .ais_in(ais), .b1_in(b1), .line_bit_out(line_bit), .frame_out(frame));
  sdpm_monitor #(.FRAMES_PER_SEC(4), .SECS_PER_INTERVAL(3)) dut (.clock_in, .sys_rst_in,
    .line_bit_in(line_bit), .frame_in(frame), .clear_current_in(clr_cur), .clear_intervals_in(clr_int),
    .clear_confirm_in(clr_cfm), .interval_sel_in(sel), .frame_alignment_loss_out(fal), .signal_loss_out(sl),
    .pointer_loss_out(pl), .second_tick_out(tick), .current_out(cur), .history_out(hist), .day_out(day),
    .elapsed_sec_out(elapsed));
  initial forever #20 clock_in = ~clock_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clock_in);
      while (!frame.frame_start) @(posedge clock_in);
    end
    #1;
  endtask : frames
  task automatic to_start();
    do frames(1); while (elapsed !== 10'h2);
    do frames(1); while (elapsed !== 10'h0);
  endtask : to_start
  task automatic t_faw();
    @(posedge clock_in) faw_bad <= 1'b1;
    frames(3);
    chk(fal, 0);
    frames(1);
    chk(fal, 1);
    @(posedge clock_in) faw_bad <= 1'b0;
    frames(1);
    chk(fal, 1);
    frames(1);
    chk(fal, 0);
    $display("test frame alignment done");
  endtask : t_faw
  task automatic t_pointer();
    @(posedge clock_in) ptr_ok <= 1'b0;
    frames(7);
    chk(pl, 0);
    frames(1);
    chk(pl, 1);
    @(posedge clock_in) ais <= 1'b1;
    #1 chk(pl, 0);
    @(posedge clock_in) ais <= 1'b0;
    #1 chk(pl, 1);
    @(posedge clock_in) ptr_ok <= 1'b1;
    frames(1);
    chk(pl, 0);
    $display("test pointer done");
  endtask : t_pointer
  task automatic t_perf();
    to_start();
    @(posedge clock_in) {ais, b1} <= 2'h3;
    frames(4);
    @(posedge clock_in) {ais, b1, sel} <= {2'h0, 7'h01};
    #1 chk(cur.coding_violation_count, 4);
    chk(cur.errored_second_count, 1);
    chk(cur.severe_error_second_count, 1);
    chk(cur.unavailable_second_count, 0);
    chk(elapsed, 1);
    to_start();
    @(posedge clock_in);
    #1 chk(hist.errored_second_count, 1);
    chk(hist.coding_violation_count, 4);
    chk(cur.coding_violation_count, 0);
    @(posedge clock_in) b1 <= 1'b1;
    frames(2);
    chk(cur.coding_violation_count, 2);
    @(posedge clock_in) {b1, clr_cur} <= 2'h1;
    @(posedge clock_in) clr_cur <= 1'b0;
    #1 chk(cur.coding_violation_count, 0);
    chk(day.unavailable_second_count != 0, 1);
    @(posedge clock_in) clr_int <= 1'b1;
    @(posedge clock_in) clr_int <= 1'b0;
    #1 chk(day.errored_second_count != 0, 1);
    @(posedge clock_in) {clr_int, clr_cfm} <= 2'h3;
    @(posedge clock_in) {clr_int, clr_cfm} <= 2'h0;
    #1 chk(day.errored_second_count, 0);
    @(posedge clock_in) #1 chk(hist.errored_second_count, 0);
    $display("test counters done");
  endtask : t_perf
  task automatic t_los();
    @(posedge clock_in) quiet <= 1'b1;
    repeat (50) @(posedge clock_in);
    #1 chk(sl, 0);
    repeat (2460) @(posedge clock_in);
    #1 chk(sl, 1);
    @(posedge clock_in) quiet <= 1'b0;
    repeat (3000) @(posedge clock_in);
    #1 chk(sl, 1);
    repeat (400) @(posedge clock_in);
    #1 chk(sl, 0);
    $display("test signal loss done");
  endtask : t_los
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Main sequence after reset
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_faw();
    t_pointer();
    t_perf();
    t_los();
    test_done();
  end
  // Watchdog on a hung run
  initial begin
    #(20000 * 40);
    err_total++;
    test_done();
  end
endmodule : testbench
